/* File: rtl/iasr_pkg.sv */
// package: register map, control fields, status codes and rate table
package iasr_pkg;
	localparam logic [7:0] ADR_CONTROL = 8'hD8;
	localparam logic [7:0] ADR_STATE_CODE = 8'hD9;
	localparam logic [7:0] ADR_DATA = 8'hDA;
	localparam logic [7:0] ADR_OWN_ADDR = 8'hDB;
	// control and own-address register fields
	localparam int CTL_RATE2 = 7;
	localparam int CTL_ENABLE = 6;
	localparam int CTL_START = 5;
	localparam int CTL_STOP = 4;
	localparam int CTL_SI = 3;
	localparam int CTL_AA = 2;
	localparam int CTL_RATE1 = 1;
	localparam int CTL_RATE0 = 0;
	localparam int OWN_GC_EN = 0;
	localparam logic [7:0] CONTROL_RST = 8'h00;
	localparam logic [7:0] OWN_ADDR_RST = 8'h00;
	localparam logic [7:0] DATA_RST = 8'h00;
	// the 26 status codes; the low three bits are always zero
	localparam logic [7:0] ST_BUS_ERR = 8'h00, ST_M_START = 8'h08, ST_M_RSTART = 8'h10,
		ST_MT_SLA_ACK = 8'h18, ST_MT_SLA_NACK = 8'h20, ST_MT_DAT_ACK = 8'h28,
		ST_MT_DAT_NACK = 8'h30, ST_M_ARB_LOST = 8'h38, ST_MR_SLA_ACK = 8'h40,
		ST_MR_SLA_NACK = 8'h48, ST_MR_DAT_ACK = 8'h50, ST_MR_DAT_NACK = 8'h58,
		ST_SR_SLA = 8'h60, ST_SR_ARB_SLA = 8'h68, ST_SR_GC = 8'h70, ST_SR_ARB_GC = 8'h78,
		ST_SR_DAT_ACK = 8'h80, ST_SR_DAT_NACK = 8'h88, ST_SR_GC_ACK = 8'h90,
		ST_SR_GC_NACK = 8'h98, ST_SR_STOP = 8'hA0, ST_ST_SLA = 8'hA8,
		ST_ST_DAT_ACK = 8'hB8, ST_ST_DAT_NACK = 8'hC0, ST_ST_LAST = 8'hC8,
		ST_NO_INFO = 8'hF8;
	// core clock divisors for rate codes 000..110
	localparam logic [11:0] RATE_DIV [0:6] = '{12'h00A, 12'h014, 12'h01E, 12'h028,
		12'h050, 12'h078, 12'h0A0};
	localparam logic [11:0] RATE_T1_MULT = 12'h00C;
	localparam logic [8:0] RATE_T1_BASE = 9'h100;
	localparam logic [2:0] RATE_T1_CODE = 3'h7;
endpackage

/* File: rtl/iasr_line_if.sv */
// interface: filtered bus levels and bus events from the line synchroniser
`timescale 1ns/10ps
`default_nettype none
interface iasr_line_if;
	logic scl;
	logic sda;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	modport src (output scl, output sda, output scl_rise, output scl_fall,
		output start_det, output stop_det);
	modport snk (input scl, input sda, input scl_rise, input scl_fall,
		input start_det, input stop_det);
endinterface
`default_nettype wire

/* File: rtl/iasr_line_sync.sv */
// module: pin synchroniser with start, stop and clock edge detection
`timescale 1ns/10ps
`default_nettype none
module iasr_line_sync (
	input wire logic clk,
	input wire logic srst,
	input wire logic scl_pin,
	input wire logic sda_pin,
	iasr_line_if.src ev
);
	typedef struct packed {
		logic [2:0] scl_sh;
		logic [2:0] sda_sh;
		logic scl;
		logic sda;
		logic rise;
		logic fall;
		logic start;
		logic stop;
	} iasr_sync_t;
	iasr_sync_t s_q, s_d;

	always_comb begin
		s_d = s_q;
		s_d.scl_sh = {s_q.scl_sh[1:0], scl_pin};
		s_d.sda_sh = {s_q.sda_sh[1:0], sda_pin};
		// a level counts once stages two and three agree
		if (s_q.scl_sh[2] == s_q.scl_sh[1]) begin
			s_d.scl = s_q.scl_sh[2];
		end
		if (s_q.sda_sh[2] == s_q.sda_sh[1]) begin
			s_d.sda = s_q.sda_sh[2];
		end
		s_d.rise = ~s_q.scl & s_d.scl;
		s_d.fall = s_q.scl & ~s_d.scl;
		s_d.start = s_q.scl & s_d.scl & s_q.sda & ~s_d.sda;
		s_d.stop = s_q.scl & s_d.scl & ~s_q.sda & s_d.sda;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s_q <= '0;
			s_q.scl_sh <= 3'h7;
			s_q.sda_sh <= 3'h7;
			s_q.scl <= 1'b1;
			s_q.sda <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign ev.scl = s_q.scl;
	assign ev.sda = s_q.sda;
	assign ev.scl_rise = s_q.rise;
	assign ev.scl_fall = s_q.fall;
	assign ev.start_det = s_q.start;
	assign ev.stop_det = s_q.stop;
endmodule
`default_nettype wire

/* File: rtl/iasr_rate_div.sv */
// module: master bit-rate divider, one tick per half bit period
`timescale 1ns/10ps
`default_nettype none
module iasr_rate_div (
	input wire logic clk,
	input wire logic srst,
	input wire logic run,
	input wire logic [2:0] rate_code,
	input wire logic [7:0] t1_reload,
	output logic tick
);
	typedef struct packed {
		logic [11:0] cnt;
		logic tick;
	} iasr_div_t;
	iasr_div_t s_q, s_d;
	logic [11:0] full;
	logic [11:0] half;

	always_comb begin
		if (rate_code == iasr_pkg::RATE_T1_CODE) begin
			full = 12'((iasr_pkg::RATE_T1_BASE - {1'b0, t1_reload}) * iasr_pkg::RATE_T1_MULT);
		end else begin
			full = iasr_pkg::RATE_DIV[rate_code];
		end
		half = full >> 1;
		s_d = s_q;
		s_d.tick = 1'b0;
		// stopped counter restarts a full half period on the next run
		if (!run) begin
			s_d.cnt = 12'h000;
		end else if (s_q.cnt >= half - 12'h001) begin
			s_d.cnt = 12'h000;
			s_d.tick = 1'b1;
		end else begin
			s_d.cnt = s_q.cnt + 12'h001;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tick = s_q.tick;

	property p_div_fastest;
		@(posedge clk) disable iff (srst)
		tick && rate_code == 3'h0 |=> !tick [*4];
	endproperty
	a_div_fastest: assert property (p_div_fastest) else $error("rate 000 tick too soon");
endmodule
`default_nettype wire

/* File: rtl/iasr_i2c_core.sv */
// module: i2c ack control, status code register and master rate logic
// Function
// - ack own or general-call address when enabled
// - ack received data bytes while flag set
// - slave transmitter last byte enters C8h
// - clearing flag in C8h releases bus
// - ack flag may be re-armed in C8h
// - not-addressed mode ignores all addresses silently
// - released unit still tracks start, stop, data
// - setting ack flag resumes address recognition
// - late ack flag still recognises current address
// - three-bit rate code selects master divisor
// - status register reads low three zeros
// - twenty-three of the twenty-six status codes occur; 38h, 68h, 78h never do
// - F8h means no info, no interrupt
// - reset loads status F8h
// - entering defined state sets interrupt and code
// - code holds until firmware clears flag
// - status follows flag one cycle later
// - F8h possible in any mode, 00h in any mode except addressed slave receiver
// - flag set holds clock line low
`timescale 1ns/10ps
`default_nettype none
module iasr_i2c_core (
	input wire logic CLK,
	input wire logic SRST,
	input wire logic [7:0] SFR_ADDR,
	input wire logic SFR_WR,
	input wire logic [7:0] SFR_WDATA,
	input wire logic SFR_RD,
	output logic [7:0] SFR_RDATA,
	input wire logic [7:0] TMR1_RELOAD,
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	output logic SCL_OUT,
	output logic SCL_OE,
	output logic SDA_OUT,
	output logic SDA_OE,
	output logic SERIAL_INT
);
	localparam int SI = iasr_pkg::CTL_SI;
	localparam int AA = iasr_pkg::CTL_AA;
	localparam int STA = iasr_pkg::CTL_START;
	localparam int STO = iasr_pkg::CTL_STOP;
	localparam logic [4:0] CODE_F8 = iasr_pkg::ST_NO_INFO[7:3];

	typedef enum logic [1:0] {PH_IDLE, PH_MSTART, PH_MBYTE, PH_MSTOP} iasr_phase_t;
	typedef struct packed {
		iasr_phase_t ph;
		logic [1:0] mstep;
		logic [7:0] ctl;
		logic [7:0] own;
		logic [7:0] shreg;
		logic [3:0] cnt;
		logic [4:0] code;
		logic [4:0] pend;
		logic busy;
		logic master;
		logic tx;
		logic addr_ph;
		logic addressed;
		logic gc;
		logic last;
		logic ackd;
		logic ackbit;
		logic na_after;
		logic mlow;
		logic scl_oe;
		logic sda_oe;
		logic lvl;
		logic [7:0] rdata;
	} iasr_core_t;

	iasr_core_t s_q, s_d;
	iasr_line_if ev ();
	logic tick;
	logic si;
	logic en;
	logic adr_own;
	logic adr_gc;
	logic ack_now;
	logic set_si;
	logic si_clr;
	logic [7:0] new_code;

	iasr_line_sync u_sync (
		.clk(CLK),
		.srst(SRST),
		.scl_pin(SCL_IN),
		.sda_pin(SDA_IN),
		.ev(ev.src)
	);

	iasr_rate_div u_div (
		.clk(CLK),
		.srst(SRST),
		.run(s_q.ph != PH_IDLE && !si),
		.rate_code({s_q.ctl[iasr_pkg::CTL_RATE2], s_q.ctl[iasr_pkg::CTL_RATE1:iasr_pkg::CTL_RATE0]}),
		.t1_reload(TMR1_RELOAD),
		.tick(tick)
	);

	assign si = s_q.ctl[SI];
	assign en = s_q.ctl[iasr_pkg::CTL_ENABLE];
	assign adr_own = s_q.shreg[7:1] == s_q.own[7:1];
	assign adr_gc = s_q.shreg[7:1] == 7'h00 && s_q.own[iasr_pkg::OWN_GC_EN];

	always_comb begin
		if (s_q.master) begin
			ack_now = s_q.ctl[AA];
		end else if (s_q.addr_ph) begin
			// no ack while flag is clear
			ack_now = s_q.ctl[AA] & (adr_own | adr_gc);
		end else begin
			ack_now = s_q.ctl[AA] & s_q.addressed;
		end
	end

	always_comb begin
		s_d = s_q;
		set_si = 1'b0;
		si_clr = 1'b0;
		new_code = iasr_pkg::ST_NO_INFO;
		s_d.rdata = 8'h00;
		if (SFR_RD) begin
			case (SFR_ADDR)
				iasr_pkg::ADR_CONTROL: s_d.rdata = s_q.ctl;
				iasr_pkg::ADR_STATE_CODE: s_d.rdata = {s_q.code, 3'h0};
				iasr_pkg::ADR_DATA: s_d.rdata = s_q.shreg;
				iasr_pkg::ADR_OWN_ADDR: s_d.rdata = s_q.own;
				default: s_d.rdata = 8'h00;
			endcase
		end
		if (SFR_WR) begin
			case (SFR_ADDR)
				iasr_pkg::ADR_CONTROL: begin
					s_d.ctl = SFR_WDATA;
					s_d.ctl[SI] = si & SFR_WDATA[SI];
					si_clr = si & ~SFR_WDATA[SI];
				end
				iasr_pkg::ADR_DATA: s_d.shreg = SFR_WDATA;
				iasr_pkg::ADR_OWN_ADDR: s_d.own = SFR_WDATA;
				default: ;
			endcase
		end

		if (si_clr) begin
			if (s_q.na_after) begin
				s_d.addressed = 1'b0;
				s_d.tx = 1'b0;
				s_d.na_after = 1'b0;
				s_d.sda_oe = 1'b0;
			end else if (s_q.master) begin
				s_d.mstep = 2'h0;
				if (SFR_WDATA[STA] && !SFR_WDATA[STO]) begin
					s_d.ph = PH_MSTART;
				end else if (SFR_WDATA[STO]) begin
					s_d.ph = PH_MSTOP;
				end else begin
					s_d.ph = PH_MBYTE;
					s_d.sda_oe = s_q.tx & ~s_q.shreg[7];
				end
			end else if (SFR_WDATA[STO]) begin
				// slave recovery: internal stop, nothing sent on the bus
				s_d.addressed = 1'b0;
				s_d.tx = 1'b0;
				s_d.ctl[STO] = 1'b0;
			end else if (s_q.addressed && s_q.tx) begin
				s_d.sda_oe = ~s_q.shreg[7];
				s_d.last = ~SFR_WDATA[AA];
			end
		end

		if (s_q.ph == PH_IDLE && en && s_q.ctl[STA] && !s_q.busy && !si) begin
			s_d.ph = PH_MSTART;
			s_d.mstep = 2'h0;
		end

		case (s_q.ph)
			PH_MSTART: begin
				if (tick) begin
					case (s_q.mstep)
						2'h0: begin
							s_d.sda_oe = 1'b0;
							s_d.mlow = 1'b0;
							if (ev.scl) begin
								s_d.mstep = 2'h1;
							end
						end
						2'h1: begin
							s_d.sda_oe = 1'b1;
							s_d.mstep = 2'h2;
						end
						default: begin
							s_d.mlow = 1'b1;
							s_d.ph = PH_MBYTE;
							s_d.master = 1'b1;
							s_d.tx = 1'b1;
							s_d.addr_ph = 1'b1;
							s_d.cnt = 4'h0;
							s_d.ctl[STA] = 1'b0;
							set_si = 1'b1;
							new_code = s_q.master ? iasr_pkg::ST_M_RSTART : iasr_pkg::ST_M_START;
						end
					endcase
				end
			end
			PH_MBYTE: begin
				// released clock waits for the line: slaves may stretch it
				if (tick && !si) begin
					if (s_q.mlow) begin
						s_d.mlow = 1'b0;
					end else if (ev.scl) begin
						s_d.mlow = 1'b1;
					end
				end
			end
			PH_MSTOP: begin
				if (tick) begin
					case (s_q.mstep)
						2'h0: begin
							s_d.sda_oe = 1'b1;
							s_d.mstep = 2'h1;
						end
						2'h1: begin
							s_d.mlow = 1'b0;
							s_d.mstep = 2'h2;
						end
						default: s_d.sda_oe = 1'b0;
					endcase
				end
			end
			default: ;
		endcase

		// bus tracked even when not addressed
		if (en && ev.start_det) begin
			if (s_q.addressed && !s_q.tx) begin
				set_si = 1'b1;
				new_code = iasr_pkg::ST_SR_STOP;
			end else if (s_q.master && s_q.ph != PH_MSTART && s_q.cnt > 4'h1) begin
				set_si = 1'b1;
				new_code = iasr_pkg::ST_BUS_ERR;
				s_d.master = 1'b0;
				s_d.ph = PH_IDLE;
				s_d.mlow = 1'b0;
				s_d.sda_oe = 1'b0;
			end
			s_d.busy = 1'b1;
			s_d.cnt = 4'h0;
			s_d.addr_ph = 1'b1;
			s_d.addressed = 1'b0;
			s_d.tx = 1'b0;
			s_d.na_after = 1'b0;
		end
		if (en && ev.stop_det) begin
			if (s_q.addressed && !s_q.tx) begin
				set_si = 1'b1;
				new_code = iasr_pkg::ST_SR_STOP;
			end else if (s_q.ph != PH_MSTOP && s_q.cnt > 4'h1) begin
				set_si = 1'b1;
				new_code = iasr_pkg::ST_BUS_ERR;
			end
			s_d.busy = 1'b0;
			s_d.cnt = 4'h0;
			s_d.addr_ph = 1'b0;
			s_d.addressed = 1'b0;
			s_d.tx = 1'b0;
			s_d.na_after = 1'b0;
			s_d.master = 1'b0;
			s_d.ph = PH_IDLE;
			s_d.mlow = 1'b0;
			s_d.sda_oe = 1'b0;
			s_d.ctl[STO] = 1'b0;
		end

		if (en && ev.scl_rise && s_q.busy) begin
			if (s_q.cnt < 4'h8) begin
				s_d.shreg = {s_q.shreg[6:0], ev.sda};
			end else begin
				s_d.ackbit = ev.sda;
			end
			s_d.cnt = s_q.cnt + 4'h1;
		end

		if (en && ev.scl_fall && s_q.busy) begin
			if (s_q.cnt == 4'h9) begin
				s_d.cnt = 4'h0;
				s_d.sda_oe = 1'b0;
				s_d.addr_ph = 1'b0;
				if (s_q.master) begin
					set_si = 1'b1;
					if (s_q.addr_ph && s_q.shreg[0]) begin
						s_d.tx = 1'b0;
						new_code = s_q.ackbit ? iasr_pkg::ST_MR_SLA_NACK : iasr_pkg::ST_MR_SLA_ACK;
					end else if (s_q.addr_ph) begin
						new_code = s_q.ackbit ? iasr_pkg::ST_MT_SLA_NACK : iasr_pkg::ST_MT_SLA_ACK;
					end else if (s_q.tx) begin
						new_code = s_q.ackbit ? iasr_pkg::ST_MT_DAT_NACK : iasr_pkg::ST_MT_DAT_ACK;
					end else begin
						new_code = s_q.ackd ? iasr_pkg::ST_MR_DAT_ACK : iasr_pkg::ST_MR_DAT_NACK;
					end
				end else if (s_q.addr_ph) begin
					if (s_q.ackd) begin
						set_si = 1'b1;
						s_d.addressed = 1'b1;
						s_d.gc = ~adr_own;
						s_d.tx = adr_own & s_q.shreg[0];
						if (adr_own && s_q.shreg[0]) begin
							new_code = iasr_pkg::ST_ST_SLA;
						end else begin
							new_code = adr_own ? iasr_pkg::ST_SR_SLA : iasr_pkg::ST_SR_GC;
						end
					end
				end else if (s_q.addressed && !s_q.tx) begin
					set_si = 1'b1;
					s_d.na_after = ~s_q.ackd;
					if (s_q.gc) begin
						new_code = s_q.ackd ? iasr_pkg::ST_SR_GC_ACK : iasr_pkg::ST_SR_GC_NACK;
					end else begin
						new_code = s_q.ackd ? iasr_pkg::ST_SR_DAT_ACK : iasr_pkg::ST_SR_DAT_NACK;
					end
				end else if (s_q.addressed) begin
					set_si = 1'b1;
					s_d.na_after = s_q.ackbit | s_q.last;
					if (s_q.ackbit) begin
						new_code = iasr_pkg::ST_ST_DAT_NACK;
					end else if (s_q.last) begin
						new_code = iasr_pkg::ST_ST_LAST;
					end else begin
						new_code = iasr_pkg::ST_ST_DAT_ACK;
					end
				end
			end else if (s_q.cnt == 4'h8) begin
				s_d.ackd = ~s_q.tx & ack_now;
				s_d.sda_oe = ~s_q.tx & ack_now;
			end else if (s_q.tx) begin
				s_d.sda_oe = ~s_q.shreg[7];
			end
		end

		if (set_si && !(si && !si_clr)) begin
			s_d.ctl[SI] = 1'b1;
			s_d.pend = new_code[7:3];
		end
		s_d.code = si ? s_q.pend : CODE_F8;
		s_d.scl_oe = s_d.ctl[SI] | s_d.mlow;
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			s_q <= '0;
			s_q.ctl <= iasr_pkg::CONTROL_RST;
			s_q.own <= iasr_pkg::OWN_ADDR_RST;
			s_q.shreg <= iasr_pkg::DATA_RST;
			s_q.code <= CODE_F8;
			s_q.pend <= CODE_F8;
		end else begin
			s_q <= s_d;
		end
	end

	assign SFR_RDATA = s_q.rdata;
	assign SCL_OUT = s_q.lvl;
	assign SCL_OE = s_q.scl_oe;
	assign SDA_OUT = s_q.lvl;
	assign SDA_OE = s_q.sda_oe;
	assign SERIAL_INT = s_q.ctl[SI];

	property p_reset_code;
		@(posedge CLK) $fell(SRST) |-> s_q.code == CODE_F8 && !si;
	endproperty
	a_reset_code: assert property (p_reset_code) else $error("status not F8h after reset");

	property p_f8_quiet;
		@(posedge CLK) disable iff (SRST)
		!si && !$past(si) |-> s_q.code == CODE_F8;
	endproperty
	a_f8_quiet: assert property (p_f8_quiet) else $error("code shown without flag");

	property p_code_lag;
		@(posedge CLK) disable iff (SRST)
		$rose(si) |-> s_q.code == CODE_F8 ##1 s_q.code == $past(s_q.pend);
	endproperty
	a_code_lag: assert property (p_code_lag) else $error("status did not trail flag");

	property p_code_hold;
		@(posedge CLK) disable iff (SRST)
		si && $past(si) && $past(si, 2) && !$past(si_clr, 2) |-> $stable(s_q.code);
	endproperty
	a_code_hold: assert property (p_code_hold) else $error("status changed while flag set");

	property p_stretch;
		@(posedge CLK) disable iff (SRST)
		si |-> SCL_OE;
	endproperty
	a_stretch: assert property (p_stretch) else $error("clock not held during flag");

	property p_no_ack_na;
		@(posedge CLK) disable iff (SRST)
		en && ev.scl_fall && s_q.busy && s_q.cnt == 4'h8 && s_q.addr_ph && !s_q.master
			&& !s_q.ctl[AA] |=> !SDA_OE;
	endproperty
	a_no_ack_na: assert property (p_no_ack_na) else $error("ack with flag clear");

	property p_ack_own;
		@(posedge CLK) disable iff (SRST)
		en && ev.scl_fall && s_q.busy && s_q.cnt == 4'h8 && s_q.addr_ph && !s_q.master
			&& s_q.ctl[AA] && adr_own |=> SDA_OE ##1 SDA_OE;
	endproperty
	a_ack_own: assert property (p_ack_own) else $error("own address not acked");

	property p_c8_leave;
		@(posedge CLK) disable iff (SRST)
		si && s_q.code == iasr_pkg::ST_ST_LAST[7:3] && si_clr |=> !SDA_OE && !s_q.addressed;
	endproperty
	a_c8_leave: assert property (p_c8_leave) else $error("C8h exit kept bus");

	property p_read_low;
		@(posedge CLK) disable iff (SRST)
		SFR_RD && SFR_ADDR == iasr_pkg::ADR_STATE_CODE |=>
			SFR_RDATA[2:0] == 3'h0 && SFR_RDATA[7:3] == $past(s_q.code);
	endproperty
	a_read_low: assert property (p_read_low) else $error("status read wrong");
endmodule
`default_nettype wire

/* File: test/iasr_bus_master_model.sv */
// bus master model that addresses the core as a slave on the wired lines
`timescale 1ns/10ps
`default_nettype none
module iasr_bus_master_model (
	input wire logic clk,
	input wire logic scl,
	input wire logic sda,
	output logic scl_oe,
	output logic sda_oe,
	output logic stuck
);
	localparam int HALF = 50;
	initial begin
		scl_oe = 1'b0;
		sda_oe = 1'b0;
		stuck = 1'b0;
	end
	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic release_scl();
		int i;
		scl_oe = 1'b0;
		i = 0;
		while (scl !== 1'b1 && i < 5000) begin
			step(1);
			i++;
		end
		if (i == 5000) stuck = 1'b1;
	endtask
	task automatic start();
		sda_oe = 1'b1;
		step(HALF);
		scl_oe = 1'b1;
		step(HALF);
	endtask
	task automatic clk_bit(input logic b, output logic s);
		sda_oe = ~b;
		step(HALF);
		release_scl();
		step(HALF / 2);
		s = sda;
		step(HALF / 2);
		scl_oe = 1'b1;
	endtask
	// msb first, ninth clock samples the acknowledge
	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
		clk_bit(1'b1, s);
		ack = ~s;
	endtask
	// slave drives the byte; ninth clock carries our acknowledge
	task automatic recv_byte(input logic ack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(1'b1, s);
			d[i] = s;
		end
		clk_bit(~ack, s);
	endtask
	task automatic stop();
		sda_oe = 1'b1;
		step(HALF);
		release_scl();
		step(HALF);
		sda_oe = 1'b0;
		step(HALF);
	endtask
endmodule
`default_nettype wire

/* File: test/testbench.sv */
// self-checking bench for the ack, status code and rate logic
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic CLK, SRST, SFR_WR, SFR_RD, ack, stuck;
	logic [7:0] SFR_ADDR, SFR_WDATA, SFR_RDATA, TMR1_RELOAD, ctl, d, got;
	logic SCL_OUT, SCL_OE, SDA_OUT, SDA_OE, SERIAL_INT, m_scl_oe, m_sda_oe;
	// open-drain lines with pull-ups
	wire logic scl_w = ~(SCL_OE | m_scl_oe);
	wire logic sda_w = ~(SDA_OE | m_sda_oe);
	int n_errors, num_checks, n, h, seed;
	logic [7:0] exp_q[$];
	iasr_i2c_core u_dut (
		.CLK(CLK),
		.SRST(SRST),
		.SFR_ADDR(SFR_ADDR),
		.SFR_WR(SFR_WR),
		.SFR_WDATA(SFR_WDATA),
		.SFR_RD(SFR_RD),
		.SFR_RDATA(SFR_RDATA),
		.TMR1_RELOAD(TMR1_RELOAD),
		.SCL_IN(scl_w),
		.SDA_IN(sda_w),
		.SCL_OUT(SCL_OUT),
		.SCL_OE(SCL_OE),
		.SDA_OUT(SDA_OUT),
		.SDA_OE(SDA_OE),
		.SERIAL_INT(SERIAL_INT)
	);
	iasr_bus_master_model u_bus (
		.clk(CLK),
		.scl(scl_w),
		.sda(sda_w),
		.scl_oe(m_scl_oe),
		.sda_oe(m_sda_oe),
		.stuck(stuck)
	);
	initial begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end
	task automatic close_out();
		if (n_errors == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic chk_bit(input logic got, input logic exp, input string what);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t %s", $time, what);
		end
	endtask
	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t read %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge CLK);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		SFR_ADDR = a;
		SFR_WDATA = v;
		SFR_WR = 1'b1;
		tick(1);
		SFR_WR = 1'b0;
		// idle cycle so a following strobe is not re-raised in the same step
		tick(1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		SFR_ADDR = a;
		SFR_RD = 1'b1;
		tick(1);
		SFR_RD = 1'b0;
		tick(1);
	endtask
	task automatic wait_si();
		n = 0;
		while (SERIAL_INT !== 1'b1 && n < 20000) begin
			tick(1);
			n++;
		end
		if (n == 20000) begin
			n_errors++;
			close_out();
		end
	endtask
	// wait for an event, check stretch and code, then clear the flag
	task automatic take(input logic [7:0] code);
		wait_si();
		chk_bit(SCL_OE, 1'b1, "no stretch while flag set");
		chk_bit(SCL_OUT | SDA_OUT, 1'b0, "line drive level not low");
		// status trails the flag by one cycle
		tick(1);
		rd(iasr_pkg::ADR_STATE_CODE, code);
		wr(iasr_pkg::ADR_CONTROL, ctl);
		tick(3);
		chk_bit(SERIAL_INT, 1'b0, "flag not cleared");
		chk_bit(SCL_OE, 1'b0, "stretch not ended");
	endtask
	// read data is due the cycle after the strobe
	always @(posedge CLK) begin
		if (SFR_RD === 1'b1) begin
			#2;
			if (exp_q.size() > 0) chk_reg(SFR_RDATA, exp_q.pop_front());
		end
	end
	always @(posedge stuck) begin
		n_errors++;
		close_out();
	end
	initial begin
		SRST = 1'b1;
		SFR_WR = 1'b0;
		SFR_RD = 1'b0;
		SFR_ADDR = 8'h00;
		SFR_WDATA = 8'h00;
		TMR1_RELOAD = 8'h00;
		ctl = 8'h00;
		n_errors = 0;
		num_checks = 0;
		seed = $urandom(32'hEC69DF6B);
		tick(5);
		SRST = 1'b0;
		tick(4);
		rd(iasr_pkg::ADR_STATE_CODE, 8'hF8);
		rd(8'h55, 8'h00);
		wr(iasr_pkg::ADR_STATE_CODE, 8'h00);
		rd(iasr_pkg::ADR_STATE_CODE, 8'hF8);
		rd(iasr_pkg::ADR_CONTROL, 8'h00);
		wr(iasr_pkg::ADR_OWN_ADDR, 8'h55);
		ctl = 8'h44;
		wr(iasr_pkg::ADR_CONTROL, ctl);
		// addressed receiver, acked then refused data
		u_bus.start();
		u_bus.send_byte(8'h54, ack);
		chk_bit(ack, 1'b1, "own address not acked");
		wait_si();
		tick(20);
		rd(iasr_pkg::ADR_STATE_CODE, 8'h60);
		take(8'h60);
		rd(iasr_pkg::ADR_STATE_CODE, 8'hF8);
		d = 8'($urandom);
		u_bus.send_byte(d, ack);
		chk_bit(ack, 1'b1, "data not acked");
		ctl = 8'h40;
		take(8'h80);
		rd(iasr_pkg::ADR_DATA, d);
		u_bus.send_byte(~d, ack);
		chk_bit(ack, 1'b0, "data acked with flag clear");
		take(8'h88);
		u_bus.stop();
		tick(20);
		chk_bit(SERIAL_INT, 1'b0, "event while not addressed");
		// released from the bus, still monitoring
		u_bus.start();
		u_bus.send_byte(8'h54, ack);
		chk_bit(ack, 1'b0, "address acked while released");
		d = 8'($urandom);
		u_bus.send_byte(d, ack);
		tick(20);
		chk_bit(SERIAL_INT, 1'b0, "interrupt while released");
		rd(iasr_pkg::ADR_DATA, d);
		u_bus.stop();
		// flag armed while the address is half received
		u_bus.start();
		fork
			u_bus.send_byte(8'h54, ack);
			begin
				tick(400);
				ctl = 8'h44;
				wr(iasr_pkg::ADR_CONTROL, ctl);
			end
		join
		chk_bit(ack, 1'b1, "late armed address missed");
		take(8'h60);
		u_bus.stop();
		take(8'hA0);
		// slave transmitter: two bytes, the second marked last
		u_bus.start();
		u_bus.send_byte(8'h55, ack);
		chk_bit(ack, 1'b1, "read address not acked");
		wait_si();
		d = 8'($urandom);
		wr(iasr_pkg::ADR_DATA, d);
		take(8'hA8);
		u_bus.recv_byte(1'b1, got);
		chk_reg(got, d);
		wait_si();
		d = 8'($urandom);
		wr(iasr_pkg::ADR_DATA, d);
		ctl = 8'h40;
		take(8'hB8);
		u_bus.recv_byte(1'b1, got);
		chk_reg(got, d);
		ctl = 8'h44;
		take(8'hC8);
		chk_bit(SDA_OE, 1'b0, "data line kept after last byte");
		rd(iasr_pkg::ADR_CONTROL, 8'h44);
		u_bus.stop();
		tick(20);
		chk_bit(SERIAL_INT, 1'b0, "event after leaving last byte state");
		// general call
		u_bus.start();
		u_bus.send_byte(8'h00, ack);
		chk_bit(ack, 1'b1, "general call not acked");
		take(8'h70);
		u_bus.send_byte(8'($urandom), ack);
		chk_bit(ack, 1'b1, "general call data not acked");
		take(8'h90);
		u_bus.stop();
		take(8'hA0);
		// master start timing for every rate code
		for (int c = 0; c < 8; c++) begin
			TMR1_RELOAD = 8'hF0 | 8'($urandom & 15);
			if (c < 7) h = int'(iasr_pkg::RATE_DIV[c]) / 2;
			else h = (256 - int'(TMR1_RELOAD)) * 6;
			ctl = {c[2], 2'b11, 3'b000, c[1:0]};
			wr(iasr_pkg::ADR_CONTROL, ctl);
			wait_si();
			chk_bit(n >= 2 * h - 2 && n <= 3 * h + 8, 1'b1, "start timing");
			tick(1);
			rd(iasr_pkg::ADR_STATE_CODE, 8'h08);
			ctl = {c[2], 3'b101, 2'b00, c[1:0]};
			wr(iasr_pkg::ADR_CONTROL, ctl);
			tick(5 * h + 40);
			chk_bit(SERIAL_INT, 1'b0, "interrupt after stop");
		end
		close_out();
	end
endmodule
`default_nettype wire
